/* rtl/bcr_pkg.sv */
package bcr_pkg;

  // Command codes
  localparam logic [7:0] CMD_READ_SETTING = 8'h54;
  localparam logic [7:0] CMD_WRITE_MODE   = 8'h55;
  localparam logic [7:0] CMD_READ_MODE    = 8'h56;
  localparam logic [7:0] CMD_RESET_VALUE  = 8'h00;

  // Setting and mode byte field positions
  localparam int unsigned BIT_BLOCK_ON  = 5;
  localparam int unsigned BIT_DIMMING   = 3;
  localparam int unsigned BIT_BACKLIGHT = 2;
  localparam int unsigned MODE_LSB      = 0;
  localparam int unsigned MODE_MSB      = 1;

  // Reset and fixed values
  localparam logic       SETTING_BIT_RESET = 1'b0;
  localparam logic [7:0] DUMMY_BYTE        = 8'h00;
  localparam logic [7:0] BRIGHTNESS_MIN    = 8'h00;
  localparam logic [7:0] BRIGHTNESS_MAX    = 8'hFF;

  // Pin bundle layout after synchronising
  localparam int unsigned PIN_W     = 11;
  localparam int unsigned PIN_DCX   = 10;
  localparam int unsigned PIN_RD_N  = 9;
  localparam int unsigned PIN_WR_N  = 8;
  localparam logic [PIN_W-1:0] PIN_IDLE = 11'h700;

  // Dimming ramp step time
  localparam int unsigned CLK_PERIOD_NS    = 40;
  localparam int unsigned RAMP_STEP_NS     = 100000;
  localparam int unsigned RAMP_STEP_CYCLES = RAMP_STEP_NS / CLK_PERIOD_NS;
  localparam logic [11:0] RAMP_DIV_LAST    = 12'(RAMP_STEP_CYCLES - 1);

  // Four content adaptive modes
  typedef enum logic [1:0] {
    BCR_MODE_OFF    = 2'b00,
    BCR_MODE_UI     = 2'b01,
    BCR_MODE_STILL  = 2'b10,
    BCR_MODE_MOVING = 2'b11
  } bcr_mode_e;

endpackage

/* rtl/bcr_dimmer.sv */
`timescale 1ns/1ps
module bcr_dimmer
  import bcr_pkg::*;
(
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  // Control
  input  wire logic       i_dimming,
  input  wire logic [7:0] i_target,
  // Level
  output logic [7:0]      o_level
);
  import bcr_pkg::*;

  logic [11:0] div_cnt;
  logic [11:0] next_div_cnt;
  logic        tick;
  logic [7:0]  next_level;

  always_comb begin
    tick         = (div_cnt == RAMP_DIV_LAST);
    next_div_cnt = tick ? 12'h000 : 12'(div_cnt + 12'h001);
    next_level   = o_level;
    // Without dimming the level snaps; with it, one step per tick (monotonic scale)
    if (!i_dimming) begin
      next_level = i_target;
    end else if (tick && (o_level < i_target)) begin
      next_level = 8'(o_level + 8'h01);
    end else if (tick && (o_level > i_target)) begin
      next_level = 8'(o_level - 8'h01);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      div_cnt <= 12'h000;
      o_level <= BRIGHTNESS_MIN;
    end else begin
      div_cnt <= next_div_cnt;
      o_level <= next_level;
    end
  end

  snap_level_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    !i_dimming |=> o_level == $past(i_target))
    else $error("level did not follow target with dimming off");

  ramp_step_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_dimming && tick && o_level < i_target) |=> o_level == 8'($past(o_level) + 8'h01))
    else $error("ramp up step wrong");

  ramp_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_dimming && !tick) |=> $stable(o_level))
    else $error("level moved between ramp ticks");

endmodule

/* rtl/bcr_regs.sv */
`timescale 1ns/1ps
// Contract
// - Command 54h requests the brightness setting, answered on following reads.
// - Block-on bit at D5, other unlabelled bits zero; off forces brightness 00h.
// - Dimming bit reported at D3; 1 enables dimming.
// - Backlight bit at D2; 0 switches backlight off, control lines low.
// - Parallel reads return a dummy first, then repeat the second value.
// - On the serial link mode the dummy byte is skipped.
// - Block-on, dimming and backlight clear on power-on, software and hardware reset.
// - Command 55h plus one parameter stores the mode from D1:D0.
// - The two-bit mode selects one of four adaptive modes.
// - Adaptive mode resets to zero on every reset.
// - Command 56h reads dummy, then the mode in D1:D0, rest zero.
// - All three commands work in every display, idle and sleep state.
// - With dimming, block-on changes ramp; backlight off acts at once.
// - Brightness scale is monotonic, 00h lowest, FFh highest.
module bcr_regs
  import bcr_pkg::*;
(
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  // Command bus pins
  input  wire logic       i_data_command_select,
  input  wire logic       i_read_strobe_n,
  input  wire logic       i_write_strobe_n,
  input  wire logic [7:0] i_data,
  output logic [7:0]      o_data,
  output logic            o_data_oe,
  // Device-level control
  input  wire logic       i_dsi_mode,
  input  wire logic       i_soft_reset,
  input  wire logic       i_setting_wr,
  input  wire logic [7:0] i_setting_data,
  input  wire logic [7:0] i_brightness_value,
  // Brightness outputs
  output logic            o_brightness_block_on,
  output logic            o_dimming_on,
  output logic            o_backlight_on,
  output logic [1:0]      o_content_adaptive_brightness,
  output logic [7:0]      o_brightness
);
  import bcr_pkg::*;

  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic             rd_prev;
  logic             wr_prev;
  logic [7:0]       cmd;
  logic             rd_seen;
  logic             block_on;
  logic             dimming;
  logic             backlight;
  bcr_mode_e        mode;
  logic [7:0]       ramp_level;

  logic             wr_rise;
  logic             rd_rise;
  logic             dcx;
  logic [7:0]       bus_data;
  logic [7:0]       setting_byte;
  logic [7:0]       mode_byte;
  logic [7:0]       ramp_target;
  logic [7:0]       next_cmd;
  logic             next_rd_seen;
  logic             next_block_on;
  logic             next_dimming;
  logic             next_backlight;
  bcr_mode_e        next_mode;
  logic [7:0]       next_data;
  logic             next_data_oe;
  logic [7:0]       next_brightness;

  // Pins come from the host's domain; only the second stage is read
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pin_meta <= PIN_IDLE;
      pin_sync <= PIN_IDLE;
      rd_prev  <= 1'b1;
      wr_prev  <= 1'b1;
    end else begin
      pin_meta <= {i_data_command_select, i_read_strobe_n, i_write_strobe_n, i_data};
      pin_sync <= pin_meta;
      rd_prev  <= pin_sync[PIN_RD_N];
      wr_prev  <= pin_sync[PIN_WR_N];
    end
  end

  always_comb begin
    dcx      = pin_sync[PIN_DCX];
    bus_data = pin_sync[7:0];
    wr_rise  = pin_sync[PIN_WR_N] & ~wr_prev;
    rd_rise  = pin_sync[PIN_RD_N] & ~rd_prev;
    setting_byte                = 8'h00;
    setting_byte[BIT_BLOCK_ON]  = block_on;
    setting_byte[BIT_DIMMING]   = dimming;
    setting_byte[BIT_BACKLIGHT] = backlight;
    mode_byte                   = 8'h00;
    mode_byte[MODE_MSB:MODE_LSB] = mode;
  end

  // No power-state gating: commands are taken in every display state
  always_comb begin
    next_cmd       = cmd;
    next_rd_seen   = rd_seen;
    next_block_on  = block_on;
    next_dimming   = dimming;
    next_backlight = backlight;
    next_mode      = mode;
    if (wr_rise && !dcx) begin
      next_cmd     = bus_data;
      next_rd_seen = 1'b0;
    end else if (wr_rise && dcx && cmd == CMD_WRITE_MODE) begin
      next_mode = bcr_mode_e'(bus_data[MODE_MSB:MODE_LSB]);
    end
    if (rd_rise && dcx) begin
      next_rd_seen = 1'b1;
    end
    if (i_setting_wr) begin
      next_block_on  = i_setting_data[BIT_BLOCK_ON];
      next_dimming   = i_setting_data[BIT_DIMMING];
      next_backlight = i_setting_data[BIT_BACKLIGHT];
    end
    if (i_soft_reset) begin
      next_block_on  = SETTING_BIT_RESET;
      next_dimming   = SETTING_BIT_RESET;
      next_backlight = SETTING_BIT_RESET;
      next_mode      = BCR_MODE_OFF;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cmd       <= CMD_RESET_VALUE;
      rd_seen   <= 1'b0;
      block_on  <= SETTING_BIT_RESET;
      dimming   <= SETTING_BIT_RESET;
      backlight <= SETTING_BIT_RESET;
      mode      <= BCR_MODE_OFF;
    end else begin
      cmd       <= next_cmd;
      rd_seen   <= next_rd_seen;
      block_on  <= next_block_on;
      dimming   <= next_dimming;
      backlight <= next_backlight;
      mode      <= next_mode;
    end
  end

  // Read answer: dummy first on the parallel bus, then the value until the next command byte
  always_comb begin
    next_data_oe = dcx && !pin_sync[PIN_RD_N]
                   && (cmd == CMD_READ_SETTING || cmd == CMD_READ_MODE);
    if (!rd_seen && !i_dsi_mode) begin
      next_data = DUMMY_BYTE;
    end else if (cmd == CMD_READ_SETTING) begin
      next_data = setting_byte;
    end else if (cmd == CMD_READ_MODE) begin
      next_data = mode_byte;
    end else begin
      next_data = DUMMY_BYTE;
    end
  end

  // Block off aims the ramp at zero; backlight off bypasses the ramp entirely
  always_comb begin
    ramp_target     = block_on ? i_brightness_value : BRIGHTNESS_MIN;
    next_brightness = backlight ? ramp_level : BRIGHTNESS_MIN;
  end

  bcr_dimmer u_dimmer (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_dimming (dimming),
    .i_target  (ramp_target),
    .o_level   (ramp_level)
  );

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_data                        <= DUMMY_BYTE;
      o_data_oe                     <= 1'b0;
      o_brightness_block_on         <= SETTING_BIT_RESET;
      o_dimming_on                  <= SETTING_BIT_RESET;
      o_backlight_on                <= SETTING_BIT_RESET;
      o_content_adaptive_brightness <= BCR_MODE_OFF;
      o_brightness                  <= BRIGHTNESS_MIN;
    end else begin
      o_data                        <= next_data;
      o_data_oe                     <= next_data_oe;
      o_brightness_block_on         <= block_on;
      o_dimming_on                  <= dimming;
      o_backlight_on                <= backlight;
      o_content_adaptive_brightness <= mode;
      o_brightness                  <= next_brightness;
    end
  end

  cmd_decode_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (wr_rise && !dcx) |=> cmd == $past(bus_data))
    else $error("command byte not latched");

  dummy_first_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (!rd_seen && !i_dsi_mode) |=> o_data == DUMMY_BYTE)
    else $error("first parallel read not dummy");

  setting_read_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (rd_seen && cmd == CMD_READ_SETTING) |=>
      o_data == {2'b00, $past(block_on), 1'b0, $past(dimming), $past(backlight), 2'b00})
    else $error("setting byte wrong");

  dsi_skip_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_dsi_mode && cmd == CMD_READ_MODE) |=> o_data == {6'h00, 2'($past(mode))})
    else $error("serial link read returned dummy");

  mode_write_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (wr_rise && dcx && cmd == CMD_WRITE_MODE && !i_soft_reset) |=>
      mode == bcr_mode_e'($past(bus_data[1:0])))
    else $error("mode not stored");

  soft_clear_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_soft_reset |=> (!block_on && !dimming && !backlight && mode == BCR_MODE_OFF) ##1
      (!o_brightness_block_on && !o_backlight_on && o_content_adaptive_brightness == 2'b00))
    else $error("software reset did not clear settings");

  backlight_off_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    $fell(backlight) |=> (!o_backlight_on && o_brightness == BRIGHTNESS_MIN))
    else $error("backlight not switched off at once");

  read_drive_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (dcx && !pin_sync[PIN_RD_N] && cmd == CMD_READ_MODE) |=> o_data_oe && o_data[7:2] == 6'h00)
    else $error("mode read not driven or upper bits set");

endmodule

/* verif/bcr_host.sv */
`timescale 1ns/1ps
module bcr_host (
  // Clock
  input  wire logic       i_sys_clk,
  // Command bus pins
  output logic            o_data_command_select,
  output logic            o_read_strobe_n,
  output logic            o_write_strobe_n,
  output logic [7:0]      o_data,
  input  wire logic [7:0] i_data,
  input  wire logic       i_data_oe
);
  initial begin
    o_data_command_select = 1'b1;
    o_read_strobe_n       = 1'b1;
    o_write_strobe_n      = 1'b1;
    o_data                = 8'hA5;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  // Select low marks a command byte, high a parameter byte
  task automatic send(input logic sel, input logic [7:0] b);
    o_data_command_select = sel;
    o_data = b;
    o_write_strobe_n = 1'b0;
    wait_clk(4);
    o_write_strobe_n = 1'b1;
    wait_clk(2);
    // Released bus flips so a stale byte is never mistaken for a live one
    o_data = ~b;
    wait_clk(2);
  endtask

  // Strobe held low long enough for the synchronised answer to settle
  task automatic fetch(output logic [7:0] b, output logic oe);
    o_data_command_select = 1'b1;
    wait_clk(1);
    o_read_strobe_n = 1'b0;
    wait_clk(5);
    b = i_data;
    oe = i_data_oe;
    o_read_strobe_n = 1'b1;
    wait_clk(4);
  endtask
endmodule

/* verif/brightness_control_command_regs_tb.sv */
`timescale 1ns/1ps
module brightness_control_command_regs_tb;
  import bcr_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst;
  logic       dsi;
  logic       soft_reset;
  logic       setting_wr;
  logic [7:0] setting_data;
  logic [7:0] bright_val;
  logic       sel, rd_n, wr_n, oe, blk, dim, bl;
  logic [7:0] host_data, dev_data, bright;
  logic [1:0] mode;
  int         failures = 0;
  int         tests_run = 0;

  always #20 sys_clk = ~sys_clk;

  bcr_regs i_bcr_regs (
    .i_sys_clk(sys_clk), .i_rst(rst), .i_data_command_select(sel),
    .i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n), .i_data(host_data),
    .o_data(dev_data), .o_data_oe(oe), .i_dsi_mode(dsi), .i_soft_reset(soft_reset),
    .i_setting_wr(setting_wr), .i_setting_data(setting_data),
    .i_brightness_value(bright_val), .o_brightness_block_on(blk), .o_dimming_on(dim),
    .o_backlight_on(bl), .o_content_adaptive_brightness(mode), .o_brightness(bright)
  );

  bcr_host i_bcr_host (
    .i_sys_clk(sys_clk), .o_data_command_select(sel), .o_read_strobe_n(rd_n),
    .o_write_strobe_n(wr_n), .o_data(host_data), .i_data(dev_data), .i_data_oe(oe)
  );

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (failures == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic read_back(input logic [7:0] cmd, input logic [7:0] exp_val, input int n);
    logic [7:0] b;
    logic       o;
    i_bcr_host.send(1'b0, cmd);
    for (int k = 0; k < n; k++) begin
      i_bcr_host.fetch(b, o);
      check({7'h00, o}, 8'h01);
      check(b, (k == 0 && !dsi) ? DUMMY_BYTE : exp_val);
    end
  endtask

  task automatic load_setting(input logic [7:0] s);
    setting_data = s;
    setting_wr = 1'b1;
    i_bcr_host.wait_clk(1);
    setting_wr = 1'b0;
    i_bcr_host.wait_clk(8);
  endtask

  task automatic test_reset_values();
    read_back(CMD_READ_SETTING, 8'h00, 2);
    read_back(CMD_READ_MODE, 8'h00, 2);
  endtask

  task automatic test_setting_read();
    load_setting(8'hFF);
    read_back(CMD_READ_SETTING, 8'h2C, 4);
    load_setting(8'h08);
    read_back(CMD_READ_SETTING, 8'h08, 2);
  endtask

  task automatic test_brightness();
    logic [7:0] lvl;
    bright_val = 8'h5A;
    load_setting(8'h24);
    check(bright, 8'h5A);
    bright_val = 8'h80;
    i_bcr_host.wait_clk(3);
    check(bright, 8'h80);
    load_setting(8'h04);
    check(bright, BRIGHTNESS_MIN);
    load_setting(8'h24);
    load_setting(8'h28);
    check(bright, BRIGHTNESS_MIN);
    check({5'h00, blk, dim, bl}, 8'h06);
    load_setting(8'h2C);
    check(bright, 8'h80);
    // Block off with dimming: no snap, then one step per ramp tick
    load_setting(8'h0C);
    check({7'h00, bright > 8'h7E}, 8'h01);
    i_bcr_host.wait_clk(5001);
    check({7'h00, (bright >= 8'h7C) && (bright <= 8'h7E)}, 8'h01);
    lvl = bright;
    load_setting(8'h2C);
    i_bcr_host.wait_clk(2600);
    check({7'h00, bright > lvl}, 8'h01);
  endtask

  task automatic test_modes();
    for (int m = 0; m < 4; m++) begin
      i_bcr_host.send(1'b0, CMD_WRITE_MODE);
      i_bcr_host.send(1'b1, 8'hFC | 8'(m));
      check({6'h00, mode}, 8'(m));
      read_back(CMD_READ_MODE, 8'(m), 3);
    end
  endtask

  task automatic test_dsi_read();
    dsi = 1'b1;
    read_back(CMD_READ_MODE, 8'h03, 2);
    read_back(CMD_READ_SETTING, 8'h2C, 1);
    dsi = 1'b0;
  endtask

  task automatic test_hw_reset();
    load_setting(8'h2C);
    i_bcr_host.send(1'b0, CMD_WRITE_MODE);
    i_bcr_host.send(1'b1, 8'h02);
    check({6'h00, mode}, 8'h02);
    rst = 1'b1;
    i_bcr_host.wait_clk(4);
    rst = 1'b0;
    i_bcr_host.wait_clk(2);
    check({4'h0, blk, dim, bl, 1'b0}, 8'h00);
    check({6'h00, mode}, 8'h00);
    check(bright, BRIGHTNESS_MIN);
    check({7'h00, oe}, 8'h00);
    read_back(CMD_READ_SETTING, 8'h00, 2);
  endtask

  task automatic test_soft_reset();
    load_setting(8'h2C);
    soft_reset = 1'b1;
    i_bcr_host.wait_clk(1);
    soft_reset = 1'b0;
    i_bcr_host.wait_clk(2);
    check({4'h0, blk, dim, bl, 1'b0}, 8'h00);
    check({6'h00, mode}, 8'h00);
    read_back(CMD_READ_SETTING, 8'h00, 2);
    read_back(CMD_READ_MODE, 8'h00, 2);
  endtask

  initial begin
    rst = 1'b1;
    dsi = 1'b0;
    soft_reset = 1'b0;
    setting_wr = 1'b0;
    setting_data = 8'h00;
    bright_val = 8'h80;
    i_bcr_host.wait_clk(4);
    rst = 1'b0;
    i_bcr_host.wait_clk(3);
    test_reset_values();
    test_setting_read();
    test_brightness();
    test_modes();
    test_dsi_read();
    test_soft_reset();
    test_hw_reset();
    end_of_test();
  end

  // Whole run needs under ten thousand cycles, mostly ramp ticks; ample margin
  initial begin
    #(40 * 20000);
    failures++;
    end_of_test();
  end
endmodule
